// *** core/lbs_pkg.sv ***
// Shared constants, codes and helper functions of the lite bus subordinate port
package lbs_pkg;

  localparam int LBS_ADDR_W  = 32;
  localparam int LBS_DATA_W  = 32;
  localparam int LBS_STRB_W  = 4;
  localparam int LBS_ID_W    = 4;
  localparam int LBS_DEPTH   = 16;
  localparam int LBS_IDX_W   = 4;
  localparam int LBS_IDX_LSB = 2;
  localparam int LBS_PROT_W  = 3;
  localparam int LBS_PROT_NS = 1;

  localparam logic [LBS_IDX_W-1:0]  LBS_SECURE_FIRST = 4'hC;
  localparam logic [1:0]            LBS_RESP_OKAY    = 2'h0;
  localparam logic [1:0]            LBS_RESP_SLVERR  = 2'h2;
  localparam logic [1:0]            LBS_RESP_DECERR  = 2'h3;
  localparam logic [2:0]            LBS_SIZE_BYTE    = 3'h0;
  localparam logic [2:0]            LBS_SIZE_HALF    = 3'h1;
  localparam logic [LBS_DATA_W-1:0] LBS_WORD_RESET   = 32'h0;

  // Byte lanes active for a transfer size at a byte offset
  function automatic logic [LBS_STRB_W-1:0] lbs_lane_mask(input logic [2:0] size, input logic [1:0] lo);
    logic [LBS_STRB_W-1:0] m;
    m = 4'hF;
    case (size)
      LBS_SIZE_BYTE: m = 4'h1 << lo;
      LBS_SIZE_HALF: m = lo[1] ? 4'hC : 4'h3;
      default:       m = 4'hF;
    endcase
    return m;
  endfunction

  // One bit per lane widened to a full byte mask
  function automatic logic [LBS_DATA_W-1:0] lbs_expand(input logic [LBS_STRB_W-1:0] lanes);
    logic [LBS_DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < LBS_STRB_W; i++)
    begin
      m[8*i +: 8] = {8{lanes[i]}};
    end
    return m;
  endfunction

  // Odd parity per byte lane
  function automatic logic [LBS_STRB_W-1:0] lbs_byte_parity(input logic [LBS_DATA_W-1:0] d);
    logic [LBS_STRB_W-1:0] p;
    p = '0;
    for (int i = 0; i < LBS_STRB_W; i++)
    begin
      p[i] = ~(^d[8*i +: 8]);
    end
    return p;
  endfunction

  // Address falls inside the storage window
  function automatic logic lbs_in_range(input logic [LBS_ADDR_W-1:0] a);
    return (a >> (LBS_IDX_LSB + LBS_IDX_W)) == '0;
  endfunction

endpackage

// *** core/lbs_byte_merge.sv ***
// Byte-lane merge of new write data into a stored word
`timescale 1ns/1ps
module lbs_byte_merge
  import lbs_pkg::*;
(
  input  wire logic [LBS_DATA_W-1:0] old_word,
  input  wire logic [LBS_DATA_W-1:0] new_word,
  input  wire logic [LBS_STRB_W-1:0] lanes,
  output logic      [LBS_DATA_W-1:0] merged
);

  logic [LBS_DATA_W-1:0] keep;

  // Lanes without a strobe keep their old byte
  assign keep   = lbs_expand(lanes);
  assign merged = (new_word & keep) | (old_word & ~keep);

endmodule

// *** core/lbs_subordinate.sv ***
// Single-beat lite bus subordinate port with word storage
// Functional notes
// - Responses carry the request's own ID
// - Responses in order or out of order
// - Write size accepted, may pick written bytes
// - Only strobed byte lanes are written
// - All-zero strobe write completes normally, unchanged
// - Read size accepted, may mask inactive lanes
// - Three-bit protection, only secure bit interpreted
// - Optional unique-ID, trace, poison signals
// - Optional parity signals over the read data channel only
`timescale 1ns/1ps
module lbs_subordinate
  import lbs_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [LBS_ADDR_W-1:0] awaddr,
  input  wire logic [LBS_PROT_W-1:0] awprot,
  input  wire logic [LBS_ID_W-1:0]   awid,
  input  wire logic                  awidunq,
  input  wire logic [2:0]            awsize,
  input  wire logic                  awtrace,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [LBS_DATA_W-1:0] wdata,
  input  wire logic [LBS_STRB_W-1:0] wstrb,
  input  wire logic                  wtrace,
  input  wire logic                  wpoison,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  output logic [LBS_ID_W-1:0]        bid,
  output logic                       bidunq,
  output logic                       btrace,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [LBS_ADDR_W-1:0] araddr,
  input  wire logic [LBS_PROT_W-1:0] arprot,
  input  wire logic [LBS_ID_W-1:0]   arid,
  input  wire logic                  aridunq,
  input  wire logic [2:0]            arsize,
  input  wire logic                  artrace,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [LBS_DATA_W-1:0]      rdata,
  output logic [1:0]                 rresp,
  output logic [LBS_ID_W-1:0]        rid,
  output logic                       ridunq,
  output logic                       rtrace,
  output logic                       rpoison,
  output logic [LBS_STRB_W-1:0]      rdatachk
);

  typedef struct packed {
    logic                                  aw_full;
    logic [LBS_ADDR_W-1:0]                 aw_addr;
    logic [LBS_PROT_W-1:0]                 aw_prot;
    logic [LBS_ID_W-1:0]                   aw_id;
    logic                                  aw_idunq;
    logic [2:0]                            aw_size;
    logic                                  aw_trace;
    logic                                  w_full;
    logic [LBS_DATA_W-1:0]                 w_data;
    logic [LBS_STRB_W-1:0]                 w_strb;
    logic                                  w_trace;
    logic                                  w_poison;
    logic                                  b_valid;
    logic [1:0]                            b_resp;
    logic [LBS_ID_W-1:0]                   b_id;
    logic                                  b_idunq;
    logic                                  b_trace;
    logic                                  r_valid;
    logic [LBS_DATA_W-1:0]                 r_data;
    logic [1:0]                            r_resp;
    logic [LBS_ID_W-1:0]                   r_id;
    logic                                  r_idunq;
    logic                                  r_trace;
    logic                                  r_poison;
    logic [LBS_STRB_W-1:0]                 r_chk;
    logic [LBS_DEPTH-1:0][LBS_DATA_W-1:0]  mem;
    logic [LBS_DEPTH-1:0]                  poison_mem;
  } lbs_state_type;

  lbs_state_type s;
  lbs_state_type next_s;

  logic                  commit;
  logic [LBS_IDX_W-1:0]  w_idx;
  logic [LBS_IDX_W-1:0]  r_idx;
  logic [LBS_STRB_W-1:0] w_lanes;
  logic [LBS_STRB_W-1:0] r_lanes;
  logic [1:0]            w_resp;
  logic [1:0]            ar_resp;
  logic [LBS_DATA_W-1:0] w_merged;
  logic [LBS_DATA_W-1:0] r_word;

  // Ready only while the holding slot is free
  assign awready = !s.aw_full;
  assign wready  = !s.w_full;
  assign arready = !s.r_valid;

  // A write completes once address and data are both held and the response slot is free
  assign commit  = s.aw_full && s.w_full && !s.b_valid;
  assign w_idx   = s.aw_addr[LBS_IDX_LSB +: LBS_IDX_W];
  assign r_idx   = araddr[LBS_IDX_LSB +: LBS_IDX_W];
  assign w_lanes = s.w_strb & lbs_lane_mask(s.aw_size, s.aw_addr[1:0]);
  assign r_lanes = lbs_lane_mask(arsize, araddr[1:0]);

  // Non-secure access to the secure words is refused
  assign w_resp  = !lbs_in_range(s.aw_addr) ? LBS_RESP_DECERR :
                   (s.aw_prot[LBS_PROT_NS] && w_idx >= LBS_SECURE_FIRST) ? LBS_RESP_SLVERR : LBS_RESP_OKAY;
  assign ar_resp = !lbs_in_range(araddr) ? LBS_RESP_DECERR :
                   (arprot[LBS_PROT_NS] && r_idx >= LBS_SECURE_FIRST) ? LBS_RESP_SLVERR : LBS_RESP_OKAY;
  assign r_word  = s.mem[r_idx] & lbs_expand(r_lanes);

  lbs_byte_merge u_merge (
    .old_word (s.mem[w_idx]),
    .new_word (s.w_data),
    .lanes    (w_lanes),
    .merged   (w_merged)
  );

  always_comb
  begin
    next_s = s;
    if (awvalid && awready)
    begin
      next_s.aw_full  = 1'b1;
      next_s.aw_addr  = awaddr;
      next_s.aw_prot  = awprot;
      next_s.aw_id    = awid;
      next_s.aw_idunq = awidunq;
      next_s.aw_size  = awsize;
      next_s.aw_trace = awtrace;
    end
    if (wvalid && wready)
    begin
      next_s.w_full   = 1'b1;
      next_s.w_data   = wdata;
      next_s.w_strb   = wstrb;
      next_s.w_trace  = wtrace;
      next_s.w_poison = wpoison;
    end
    if (bvalid && bready)
    begin
      next_s.b_valid = 1'b0;
    end
    if (commit)
    begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.b_valid = 1'b1;
      next_s.b_resp  = w_resp;
      next_s.b_id    = s.aw_id;
      next_s.b_idunq = s.aw_idunq;
      next_s.b_trace = s.aw_trace | s.w_trace;
      if (w_resp == LBS_RESP_OKAY)
      begin
        next_s.mem[w_idx] = w_merged;
        if (w_lanes != '0)
        begin
          next_s.poison_mem[w_idx] = s.w_poison;
        end
      end
    end
    if (rvalid && rready)
    begin
      next_s.r_valid = 1'b0;
    end
    if (arvalid && arready)
    begin
      next_s.r_valid  = 1'b1;
      next_s.r_resp   = ar_resp;
      next_s.r_id     = arid;
      next_s.r_idunq  = aridunq;
      next_s.r_trace  = artrace;
      next_s.r_data   = (ar_resp == LBS_RESP_OKAY) ? r_word : LBS_WORD_RESET;
      next_s.r_poison = (ar_resp == LBS_RESP_OKAY) && s.poison_mem[r_idx];
      next_s.r_chk    = lbs_byte_parity(next_s.r_data);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign bvalid   = s.b_valid;
  assign bresp    = s.b_resp;
  assign bid      = s.b_id;
  assign bidunq   = s.b_idunq;
  assign btrace   = s.b_trace;
  assign rvalid   = s.r_valid;
  assign rdata    = s.r_data;
  assign rresp    = s.r_resp;
  assign rid      = s.r_id;
  assign ridunq   = s.r_idunq;
  assign rtrace   = s.r_trace;
  assign rpoison  = s.r_poison;
  assign rdatachk = s.r_chk;

  // Checks
  logic [LBS_ID_W-1:0] hold_awid;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_awid <= '0;
    end
    else if (awvalid && awready)
    begin
      hold_awid <= awid;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_bid_mirror;
    $rose(bvalid) |-> bid == hold_awid;
  endproperty
  a_bid_mirror: assert property (p_bid_mirror) else $error("write response id mismatch");

  property p_rid_mirror;
    arvalid && arready |=> rvalid && rid == $past(arid);
  endproperty
  a_rid_mirror: assert property (p_rid_mirror) else $error("read response id mismatch");

  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bid) && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped or changed");

  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rid) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped or changed");

  property p_zero_strobe;
    commit && w_lanes == '0 && w_resp == LBS_RESP_OKAY |=> bvalid && bresp == LBS_RESP_OKAY && $stable(s.mem);
  endproperty
  a_zero_strobe: assert property (p_zero_strobe) else $error("empty strobe write misbehaved");

  property p_lane_keep;
    commit |=> (s.mem[$past(w_idx)] & ~lbs_expand($past(w_lanes))) == ($past(s.mem[w_idx]) & ~lbs_expand($past(w_lanes)));
  endproperty
  a_lane_keep: assert property (p_lane_keep) else $error("unstrobed byte altered");

  property p_read_lanes;
    arvalid && arready |=> (rdata & ~lbs_expand($past(r_lanes))) == '0;
  endproperty
  a_read_lanes: assert property (p_read_lanes) else $error("inactive read lane driven");

  property p_secure;
    arvalid && arready && lbs_in_range(araddr) && arprot[LBS_PROT_NS] && r_idx >= LBS_SECURE_FIRST
      |=> rresp == LBS_RESP_SLVERR && rdata == '0;
  endproperty
  a_secure: assert property (p_secure) else $error("non-secure read of secure word allowed");

  property p_write_done;
    awvalid && awready && wvalid && wready && !bvalid |-> ##[1:2] bvalid;
  endproperty
  a_write_done: assert property (p_write_done) else $error("write response late");

  property p_parity;
    rvalid |-> rdatachk == lbs_byte_parity(rdata);
  endproperty
  a_parity: assert property (p_parity) else $error("read parity wrong");

  c_zero_strobe: cover property (commit && w_lanes == '0);
  c_narrow_read: cover property (arvalid && arready && arsize == LBS_SIZE_BYTE);
  c_secure_err:  cover property (bvalid && bresp == LBS_RESP_SLVERR);
  c_back_read:   cover property (rvalid && rready ##1 arvalid && arready);

endmodule

// *** testbench/lbs_manager.sv ***
// Bus manager model issuing single-beat writes and reads
`timescale 1ns/1ps
module lbs_manager
  import lbs_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  awready,
  input  wire logic                  wready,
  input  wire logic                  bvalid,
  input  wire logic                  bidunq,
  input  wire logic                  btrace,
  input  wire logic                  arready,
  input  wire logic                  rvalid,
  input  wire logic                  ridunq,
  input  wire logic                  rtrace,
  input  wire logic                  rpoison,
  input  wire logic [1:0]            bresp,
  input  wire logic [1:0]            rresp,
  input  wire logic [LBS_ID_W-1:0]   bid,
  input  wire logic [LBS_ID_W-1:0]   rid,
  input  wire logic [LBS_DATA_W-1:0] rdata,
  input  wire logic [LBS_STRB_W-1:0] rdatachk,
  output logic                       awvalid,
  output logic                       awidunq,
  output logic                       awtrace,
  output logic                       wvalid,
  output logic                       wtrace,
  output logic                       wpoison,
  output logic                       bready,
  output logic                       arvalid,
  output logic                       aridunq,
  output logic                       artrace,
  output logic                       rready,
  output logic [LBS_ADDR_W-1:0]      awaddr,
  output logic [LBS_ADDR_W-1:0]      araddr,
  output logic [LBS_PROT_W-1:0]      awprot,
  output logic [LBS_PROT_W-1:0]      arprot,
  output logic [LBS_ID_W-1:0]        awid,
  output logic [LBS_ID_W-1:0]        arid,
  output logic [2:0]                 awsize,
  output logic [2:0]                 arsize,
  output logic [LBS_DATA_W-1:0]      wdata,
  output logic [LBS_STRB_W-1:0]      wstrb
);
  initial
  begin
    {awvalid, awidunq, awtrace, wvalid, wtrace, wpoison, bready, arvalid, aridunq, artrace, rready} = '0;
    {awaddr, araddr, awprot, arprot, awid, arid, awsize, arsize, wdata, wstrb} = '0;
  end

  // Address and data offered together; each released and scrambled once taken
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [2:0] sz, pr, input logic [3:0] id,
                    input logic psn, input int stall, output logic [1:0] resp, output logic [3:0] idr,
                    output logic [1:0] side);
    int   n;
    logic ta;
    logic tw;
    @(negedge clk);
    {awvalid, awaddr, awsize, awprot, awid, awidunq, awtrace} = {1'b1, a, sz, pr, id, id[0], id[1]};
    {wvalid, wdata, wstrb, wpoison, wtrace} = {1'b1, d, s, psn, id[2]};
    n = 0;
    while ((awvalid || wvalid) && n < 50)
    begin
      ta = awready;
      tw = wready;
      @(negedge clk);
      if (ta) {awvalid, awaddr} = {1'b0, ~awaddr};
      if (tw) {wvalid, wdata} = {1'b0, ~wdata};
      n++;
    end
    repeat (stall) @(negedge clk);
    bready = 1'b1;
    n = 0;
    while (!bvalid && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    // No answer in time leaves the results unknown, so the caller's check fails
    {resp, idr, side} = bvalid ? {bresp, bid, bidunq, btrace} : 'x;
    @(negedge clk);
    bready = 1'b0;
  endtask

  // Single read with an optional stall before accepting the data
  task automatic rd(input logic [31:0] a, input logic [2:0] sz, pr, input logic [3:0] id, input int stall,
                    output logic [31:0] d, output logic [1:0] resp, output logic [3:0] idr,
                    output logic [3:0] chk, output logic psn, output logic [1:0] side);
    int n;
    @(negedge clk);
    {arvalid, araddr, arsize, arprot, arid, aridunq, artrace} = {1'b1, a, sz, pr, id, id[0], id[1]};
    n = 0;
    while (!arready && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    {arvalid, araddr} = {1'b0, ~araddr};
    repeat (stall) @(negedge clk);
    rready = 1'b1;
    n = 0;
    while (!rvalid && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    {d, resp, idr, chk, psn, side} = rvalid ? {rdata, rresp, rid, rdatachk, rpoison, ridunq, rtrace} : 'x;
    @(negedge clk);
    rready = 1'b0;
  endtask
endmodule

// *** testbench/lite_bus_subordinate_port_bench.sv ***
// Self-checking bench of the lite bus subordinate port
`timescale 1ns/1ps
module lite_bus_subordinate_port_bench
  import lbs_pkg::*;
;
  logic                  clk, resetn, awvalid, awready, awidunq, awtrace, wvalid, wready, wtrace, wpoison;
  logic                  bvalid, bready, bidunq, btrace, arvalid, arready, aridunq, artrace;
  logic                  rvalid, rready, ridunq, rtrace, rpoison;
  logic [LBS_ADDR_W-1:0] awaddr, araddr;
  logic [LBS_PROT_W-1:0] awprot, arprot;
  logic [LBS_ID_W-1:0]   awid, arid, bid, rid;
  logic [2:0]            awsize, arsize;
  logic [1:0]            bresp, rresp;
  logic [LBS_DATA_W-1:0] wdata, rdata;
  logic [LBS_STRB_W-1:0] wstrb, rdatachk;
  int                    n_errors = 0;
  int                    n_tests = 0;

  lbs_subordinate uut (.*);
  lbs_manager     mgr (.*);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic final_report;
    $display("Tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic w(input logic [31:0] a, d, input logic [3:0] s, input logic [2:0] sz, pr, input logic [3:0] id,
                   input logic [1:0] er, input logic psn = 1'b0);
    logic [1:0] rs;
    logic [3:0] ir;
    logic [1:0] sd;
    mgr.wr(a, d, s, sz, pr, id, psn, a[2] ? 3 : 0, rs, ir, sd);
    check(rs === er && ir === id, "write response");
    check(sd === {id[0], id[1] | id[2]}, "write sideband");
  endtask

  task automatic r(input logic [31:0] a, input logic [2:0] sz, pr, input logic [3:0] id, input logic [1:0] er,
                   input logic [31:0] ed, input logic ep = 1'b0);
    logic [31:0] d;
    logic [1:0]  rs;
    logic [3:0]  ir;
    logic [3:0]  c;
    logic        p;
    logic [1:0]  sd;
    mgr.rd(a, sz, pr, id, a[3] ? 2 : 0, d, rs, ir, c, p, sd);
    check(rs === er && ir === id && d === ed && p === ep, "read response");
    check(sd === {id[0], id[1]}, "read sideband");
    check(c === {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]}, "read parity");
  endtask

  // Full words, poison and id mirroring
  task automatic t_full;
    w(32'h04, 32'hA5A51234, 4'hF, 3'h2, 3'h0, 4'h3, LBS_RESP_OKAY, 1'b1);
    r(32'h04, 3'h2, 3'h0, 4'h9, LBS_RESP_OKAY, 32'hA5A51234, 1'b1);
    w(32'h00, 32'h0BADF00D, 4'hF, 3'h2, 3'h0, 4'h0, LBS_RESP_OKAY);
    r(32'h00, 3'h2, 3'h0, 4'h0, LBS_RESP_OKAY, 32'h0BADF00D);
  endtask

  // Partial and empty strobes
  task automatic t_strobe;
    w(32'h08, 32'h11223344, 4'hF, 3'h2, 3'h0, 4'h1, LBS_RESP_OKAY);
    w(32'h08, 32'hAABBCCDD, 4'h5, 3'h2, 3'h0, 4'h2, LBS_RESP_OKAY);
    r(32'h08, 3'h2, 3'h0, 4'h4, LBS_RESP_OKAY, 32'h11BB33DD);
    w(32'h08, 32'hFFFFFFFF, 4'h0, 3'h2, 3'h0, 4'h5, LBS_RESP_OKAY);
    r(32'h08, 3'h2, 3'h0, 4'h6, LBS_RESP_OKAY, 32'h11BB33DD);
  endtask

  // Narrow writes and reads
  task automatic t_size;
    w(32'h0C, 32'h76543210, 4'hF, 3'h2, 3'h0, 4'h7, LBS_RESP_OKAY);
    w(32'h0E, 32'h00AB0000, 4'hF, LBS_SIZE_BYTE, 3'h0, 4'h8, LBS_RESP_OKAY);
    r(32'h0C, LBS_SIZE_HALF, 3'h0, 4'hA, LBS_RESP_OKAY, 32'h00003210);
    r(32'h0E, LBS_SIZE_HALF, 3'h0, 4'hB, LBS_RESP_OKAY, 32'h76AB0000);
    r(32'h0E, LBS_SIZE_BYTE, 3'h0, 4'hC, LBS_RESP_OKAY, 32'h00AB0000);
  endtask

  // Protection and decode errors
  task automatic t_prot;
    r(32'h34, 3'h2, 3'h0, 4'h1, LBS_RESP_OKAY, 32'h0);
    w(32'h30, 32'hCAFE0001, 4'hF, 3'h2, 3'h2, 4'h2, LBS_RESP_SLVERR);
    w(32'h30, 32'hCAFE0002, 4'hF, 3'h2, 3'h5, 4'h3, LBS_RESP_OKAY);
    r(32'h30, 3'h2, 3'h7, 4'h4, LBS_RESP_SLVERR, 32'h0);
    r(32'h30, 3'h2, 3'h1, 4'h5, LBS_RESP_OKAY, 32'hCAFE0002);
    w(32'h40, 32'h1, 4'hF, 3'h2, 3'h0, 4'h6, LBS_RESP_DECERR);
    r(32'h40, 3'h2, 3'h0, 4'hF, LBS_RESP_DECERR, 32'h0);
  endtask

  // Second reset empties every slot and clears words and poison
  task automatic t_reset;
    @(negedge clk);
    resetn = 1'b0;
    @(negedge clk);
    check(awready === 1'b1 && wready === 1'b1 && arready === 1'b1, "ready in reset");
    check(bvalid === 1'b0 && rvalid === 1'b0 && rdatachk === 4'h0, "idle in reset");
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    r(32'h04, 3'h2, 3'h0, 4'h2, LBS_RESP_OKAY, 32'h0);
  endtask

  initial
  begin
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    t_full;
    t_strobe;
    t_size;
    t_prot;
    t_reset;
    final_report;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    final_report;
  end
endmodule
